// File: dv/flash_read_model.sv
`timescale 1ns/1ps
module flash_read_model (
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [2:0] lanes,
	input wire logic [127:0] image,
	output logic [3:0] d_in
);
	logic [127:0] shift_q;
	logic [3:0] lane_v;
	always @(negedge cs_n)
		shift_q = image;
	// Launching on the fall keeps each bit steady across the port's falling sample.
	always @(negedge sclk)
		if (!cs_n)
			shift_q = shift_q << lanes;
	assign lane_v = lanes == 3'h4 ? shift_q[127:124] :
		lanes == 3'h2 ? {2'h0, shift_q[127:126]} : {2'h0, shift_q[127], 1'h0};
	// Deselected lines show the inverse so a stale bit never passes as data.
	assign d_in = cs_n ? ~lane_v : lane_v;
endmodule : flash_read_model

// File: dv/qspi_read_properties.sv
`timescale 1ns/1ps
`include "qspi_read_consts.svh"
module qspi_read_checker (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [1:0] pin_config,
	input wire logic busy,
	input wire logic word_done,
	input wire logic frame_done,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic [3:0] d_out,
	input wire logic [3:0] d_oe_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	property p_take; !busy && start |=> !cs_n && busy; endproperty
	property p_sel; !cs_n |-> busy; endproperty
	property p_idle; cs_n |-> !sclk; endproperty
	property p_oe_on; $fell(cs_n) && pin_config != `PINS_3 |-> d_oe_n == 4'hE; endproperty
	property p_oe_off; cs_n && $past(cs_n) |-> d_oe_n == 4'hF; endproperty
	property p_dout; !$stable(d_out) && !cs_n |-> !sclk; endproperty
	property p_word; word_done |=> !word_done; endproperty
	property p_frame; frame_done |-> !cs_n ##1 !frame_done; endproperty
	property p_lag; $rose(cs_n) |-> !$past(sclk) && !$past(sclk, 2) && !$past(sclk, 3); endproperty
	property p_rise; $rose(sclk) |-> !cs_n; endproperty
	property p_oe_three; $fell(cs_n) && pin_config == `PINS_3 |-> d_oe_n == 4'hF; endproperty
	a_take: assert property (p_take) else $error("start not taken");
	a_sel: assert property (p_sel) else $error("select without busy");
	a_idle: assert property (p_idle) else $error("clock not idle low");
	a_oe_on: assert property (p_oe_on) else $error("line not driven");
	a_oe_off: assert property (p_oe_off) else $error("line driven idle");
	a_dout: assert property (p_dout) else $error("data moved high");
	a_word: assert property (p_word) else $error("word pulse long");
	a_frame: assert property (p_frame) else $error("frame pulse bad");
	a_lag: assert property (p_lag) else $error("release too soon");
	a_rise: assert property (p_rise) else $error("clock unselected");
	a_oe_three: assert property (p_oe_three) else $error("line driven in three-pin");
	c_frame: cover property (frame_done);
	c_word: cover property (word_done);
	c_sel: cover property ($fell(cs_n));
endmodule : qspi_read_checker
////////////////////////////////////////////////////////////
bind quad_spi_read_port qspi_read_checker u_qspi_read_checker (.*);

// File: dv/testbench.sv
`timescale 1ns/1ps
`include "qspi_read_consts.svh"
module testbench;
	localparam logic [127:0] PAT = 128'hF0E1D2C3B4A5968778695A4B3C2D1E0F;
	logic clk_sys = 0, start = 0, wen = 0, fen = 0, rst_n;
	logic [7:0] dv = 0;
	logic [6:0] len = 0;
	logic [11:0] cnt = 0;
	logic [1:0] dly = 0, md = 0;
	logic [2:0] lanes = 1;
	logic [1:0] pc = `PINS_6;
	logic busy, word_done, frame_done, sclk, cs_n, sclk_p, cs_p;
	logic [127:0] rx_word;
	logic [3:0] d_in;
	int err_total, check_count, tick, t0, ff, lf, lag, hi, hw, wd, fd;
	always #4 clk_sys = ~clk_sys;
	quad_spi_read_port u_quad_spi_read_port (.clk_sys, .rst_n, .start,
		.serial_clock_divide_factor(dv), .word_len_m1(len), .word_count_m1(cnt),
		.select_to_data_delay_field(dly), .read_mode(md), .pin_config(pc),
		.word_irq_en(wen), .frame_irq_en(fen), .tx_word(PAT), .busy, .word_done,
		.frame_done, .rx_word, .sclk, .cs_n, .d_in, .d_out(), .d_oe_n());
	flash_read_model u_flash_read_model (.sclk, .cs_n, .lanes, .image(PAT), .d_in);
	always @(posedge clk_sys)
	begin
		tick <= tick + 1;
		sclk_p <= sclk;
		cs_p <= cs_n;
		hi <= sclk ? hi + 1 : 0;
		wd <= wd + word_done;
		fd <= fd + frame_done;
		if (cs_p && !cs_n)
			t0 <= tick;
		if (sclk_p && !sclk)
		begin
			lf <= tick;
			hw <= hi;
			if (ff == 0)
				ff <= tick - t0;
		end
		if (!cs_p && cs_n)
			lag <= tick - lf;
		if (tick == 20000)
		begin
			err_total++;
			test_done();
		end
	end
	task chk(input string s, input logic [127:0] v, input logic [127:0] e);
		check_count++;
		if (v !== e)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", s, e, v);
		end
	endtask : chk
	task test_done();
		if (err_total == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	// A second start cycle while busy must be ignored, so start is held for two.
	task automatic run(input logic [35:0] c, input logic [127:0] x);
		int k;
		{md, lanes, len, cnt, dly, dv, wen, fen} = c;
		ff = 0;
		wd = 0;
		fd = 0;
		start = 1;
		repeat (2) @(negedge clk_sys);
		start = 0;
		k = 0;
		while (busy !== 1'b0 && k < 9000)
		begin
			@(negedge clk_sys);
			k++;
		end
		@(negedge clk_sys);
		chk("rx", rx_word, x);
		chk("lead", ff, (dly + 1) * (dv + 1));
		chk("lag", lag, 2 * (dv + 1));
		chk("high", hw, dv[0] ? (dv + 1) / 2 : dv / 2);
		chk("words", wd, wen ? cnt + 1 : 0);
		chk("frames", fd, fen);
	endtask : run
	initial
	begin
		rst_n = 0;
		repeat (3) @(negedge clk_sys);
		rst_n = 1;
		run({`MODE_SINGLE, 3'h1, 7'h7, 12'h0, 2'h0, 8'h3, 2'h3}, PAT[127:120]);
		run({`MODE_DUAL, 3'h2, 7'h7, 12'h1, 2'h3, 8'h4, 2'h1}, PAT[119:112]);
		run({`MODE_QUAD, 3'h4, 7'h7F, 12'h0, 2'h1, 8'h5, 2'h2}, PAT);
		pc = `PINS_3;
		run({`MODE_SINGLE, 3'h1, 7'h0, 12'h2, 2'h2, 8'h3, 2'h3}, {127'h0, PAT[125]});
		test_done();
	end
endmodule : testbench

// File: src/qspi_read_consts.svh
`ifndef QSPI_READ_CONSTS_SVH
`define QSPI_READ_CONSTS_SVH
`define DIV_W 8
`define LEN_W 7
`define CNT_W 12
`define DLY_W 2
`define WORD_W 128
`define LAG_PERIODS 2
`define MODE_SINGLE 2'h0
`define MODE_DUAL 2'h1
`define MODE_QUAD 2'h2
`define PINS_3 2'h0
`define PINS_4 2'h1
`define PINS_6 2'h2
`endif

// File: src/qspi_read_pkg.sv
package qspi_read_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_LEAD = 3'b001,
		ST_SHIFT = 3'b010,
		ST_LAG = 3'b011
	} qstate_t;
endpackage : qspi_read_pkg

// File: src/quad_spi_read_port.sv
// Functional notes
// - Master only: always drives serial clock and chip select, never a target.
// - Reads over one, two or four data lines, chosen per frame.
// - Word length programmable from 1 to 128 bits.
// - Frame is 1 to 4096 words with chip select held throughout.
// - Separately enabled word-done and frame-done event pulses.
// - Zero to three serial clock delay between select and first data.
// - Three-, four- or six-pin interface selectable.
// - Clock divider; zero or odd factor symmetric, even factor N high (N/2)/(N+1).
// - Clock mode zero: idle low, phase zero.
// - Incoming data sampled on falling serial clock edge.
// - Select asserted delay-plus-one periods before first falling edge.
// - Select released two periods after last falling edge.
// - Output changes on falling edges; first bit driven with select, delay-plus-one periods before first fall.
// - Output line enabled with select except in three-pin mode, released after frame.
`timescale 1ns/1ps
`include "qspi_read_consts.svh"
module quad_spi_read_port
	import qspi_read_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [`DIV_W-1:0] serial_clock_divide_factor,
	input wire logic [`LEN_W-1:0] word_len_m1,
	input wire logic [`CNT_W-1:0] word_count_m1,
	input wire logic [`DLY_W-1:0] select_to_data_delay_field,
	input wire logic [1:0] read_mode,
	input wire logic [1:0] pin_config,
	input wire logic word_irq_en,
	input wire logic frame_irq_en,
	input wire logic [`WORD_W-1:0] tx_word,
	output logic busy,
	output logic word_done,
	output logic frame_done,
	output logic [`WORD_W-1:0] rx_word,
	output logic sclk,
	output logic cs_n,
	input wire logic [3:0] d_in,
	output logic [3:0] d_out,
	output logic [3:0] d_oe_n
);
	////////////////////////////////////////////////////////////////////////////
	logic [3:0] d_s1_q;
	logic [3:0] d_s2_q;
	qstate_t st_q;
	logic [`DIV_W:0] ph_cnt_q;
	logic [`DIV_W-1:0] div_q;
	logic [1:0] mode_q;
	logic [1:0] pins_q;
	logic [`LEN_W-1:0] len_q;
	logic [`CNT_W-1:0] cnt_q;
	logic [`CNT_W-1:0] words_q;
	logic [`LEN_W:0] bit_q;
	logic [1:0] lead_q;
	logic [1:0] lag_q;
	logic [`WORD_W-1:0] sh_q;
	logic [`WORD_W-1:0] tx_q;
	logic wen_q;
	logic fen_q;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			d_s1_q <= 4'h0;
			d_s2_q <= 4'h0;
		end
		else
		begin
			d_s1_q <= d_in;
			d_s2_q <= d_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Half-period lengths: an even factor N gives high N/2 and low N/2+1 ticks,
	// so the whole period is N+1 ticks; zero or odd gives equal halves.
	wire [`DIV_W:0] div_ext = {1'b0, div_q};
	wire div_even = (div_q != 8'h00) && !div_q[0];
	wire [`DIV_W:0] half_odd = (div_ext + 9'h001) >> 1;
	wire [`DIV_W:0] high_len = div_even ? (div_ext >> 1) : half_odd;
	wire [`DIV_W:0] low_len = div_even ? ((div_ext >> 1) + 9'h001) : half_odd;
	// Lead and lag count whole serial periods of N+1 ticks, not single halves.
	wire [`DIV_W:0] per_len = high_len + low_len;
	wire [`DIV_W:0] cur_len = (st_q != ST_SHIFT) ? per_len : (sclk ? high_len : low_len);
	wire ph_end = (ph_cnt_q + 9'h001) >= cur_len;
	wire fall = ph_end && sclk;
	wire rise = ph_end && !sclk;
	wire period_end = fall || (ph_end && (st_q != ST_SHIFT));
	// Bits carried per falling edge on the chosen data width.
	wire [2:0] step = (mode_q == `MODE_QUAD) ? 3'h4 : (mode_q == `MODE_DUAL) ? 3'h2 : 3'h1;
	wire [`LEN_W:0] bit_next = bit_q + {5'h00, step};
	wire word_end = fall && (bit_next > {1'b0, len_q});
	wire frame_end = word_end && (words_q == cnt_q);
	wire [3:0] in_bits = d_s2_q;
	logic [`WORD_W-1:0] sh_next;
	always_comb
	begin
		case (mode_q)
			`MODE_QUAD: sh_next = {sh_q[`WORD_W-5:0], in_bits};
			`MODE_DUAL: sh_next = {sh_q[`WORD_W-3:0], in_bits[1:0]};
			default: sh_next = {sh_q[`WORD_W-2:0], in_bits[1]};
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Period counter runs only while a frame is open; the clock stays low idle.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= ST_IDLE;
			ph_cnt_q <= 9'h000;
			sclk <= 1'b0;
			cs_n <= 1'b1;
			busy <= 1'b0;
			div_q <= 8'h00;
			mode_q <= `MODE_SINGLE;
			pins_q <= `PINS_6;
			len_q <= 7'h00;
			cnt_q <= 12'h000;
			words_q <= 12'h000;
			bit_q <= 8'h00;
			lead_q <= 2'h0;
			lag_q <= 2'h0;
			sh_q <= 128'h0;
			tx_q <= 128'h0;
			wen_q <= 1'b0;
			fen_q <= 1'b0;
			rx_word <= 128'h0;
			word_done <= 1'b0;
			frame_done <= 1'b0;
			d_out <= 4'h0;
			d_oe_n <= 4'hF;
		end
		else
		begin
			word_done <= 1'b0;
			frame_done <= 1'b0;
			ph_cnt_q <= (st_q == ST_IDLE || ph_end) ? 9'h000 : ph_cnt_q + 9'h001;
			case (st_q)
				ST_IDLE:
				begin
					sclk <= 1'b0;
					if (start)
					begin
						div_q <= serial_clock_divide_factor;
						mode_q <= read_mode;
						pins_q <= pin_config;
						len_q <= word_len_m1;
						cnt_q <= word_count_m1;
						lead_q <= select_to_data_delay_field - 2'h1;
						sh_q <= 128'h0;
						wen_q <= word_irq_en;
						fen_q <= frame_irq_en;
						tx_q <= tx_word;
						words_q <= 12'h000;
						bit_q <= 8'h00;
						cs_n <= 1'b0;
						busy <= 1'b1;
						d_oe_n <= (pin_config == `PINS_3) ? 4'hF : 4'hE;
						d_out <= {3'h0, tx_word[`WORD_W-1]};
						// With no delay the first clock period is the whole lead.
						if (select_to_data_delay_field == 2'h0)
							st_q <= ST_SHIFT;
						else
							st_q <= ST_LEAD;
					end
				end
				ST_LEAD:
				begin
					// Select leads the first fall by delay+1 periods, the last of
					// which is the first clock period itself.
					if (period_end)
					begin
						if (lead_q == 2'h0)
							st_q <= ST_SHIFT;
						else
							lead_q <= lead_q - 2'h1;
					end
				end
				ST_SHIFT:
				begin
					if (rise)
						sclk <= 1'b1;
					if (fall)
					begin
						sclk <= 1'b0;
						// Each word starts from zero so a short word reads right-aligned.
						sh_q <= word_end ? 128'h0 : sh_next;
						tx_q <= {tx_q[`WORD_W-2:0], 1'b0};
						d_out <= {3'h0, tx_q[`WORD_W-2]};
						bit_q <= word_end ? 8'h00 : bit_next;
					end
					if (word_end)
					begin
						rx_word <= sh_next;
						word_done <= wen_q;
						words_q <= words_q + 12'h001;
					end
					if (frame_end)
					begin
						frame_done <= fen_q;
						lag_q <= 2'(`LAG_PERIODS - 1);
						st_q <= ST_LAG;
					end
				end
				ST_LAG:
				begin
					sclk <= 1'b0;
					if (period_end)
					begin
						if (lag_q == 2'h0)
						begin
							cs_n <= 1'b1;
							d_oe_n <= 4'hF;
							d_out <= 4'h0;
							busy <= 1'b0;
							st_q <= ST_IDLE;
						end
						else
							lag_q <= lag_q - 2'h1;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end
endmodule : quad_spi_read_port
